// ==== conditional_branch_unit.sv ====
// Decode and execute stage for conditional relative branches.
// Assumes the core presents a one-cycle issue strobe with a command that
// is stable in that cycle, and holds further issues while busy is high.

// Functional notes
// (RQ1) Equal branches on null flag 1, not-equal on null flag 0.
// (RQ2) Carry-set branches on overflow bit 1, carry-clear on 0.
// (RQ3) Same-or-higher uses carry clear; lower uses carry set.
// (RQ4) Minus branches on msb bit 1, plus on msb bit 0.
// (RQ5) Signed greater-or-equal branches when msb xor wrap bit is 0.
// (RQ6) Signed less-than branches when msb xor wrap bit is 1.
// (RQ7) Half-carry-set branches only when nibble carry is 1.
// (RQ8) Half-carry-clear branches only when nibble carry is 0.
// (RQ9) Spare-flag-set branches only when spare flag is set.
// (RQ10) Taken branch loads pc plus offset plus one; else sequential.
// (RQ11) No status flag is altered, taken or not.
// (RQ12) Each branch completes in one or two cycles by outcome.
// (RQ13) Not taken takes one cycle; taken takes two with refetch.
module conditional_branch_unit (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic branch_issue,
  input wire branch_unit_pkg::branch_cmd_s cmd,
  output logic pc_load,
  output logic [branch_unit_pkg::PC_W-1:0] pc_target,
  output logic busy,
  output logic done,
  output logic taken,
  output branch_unit_pkg::flags_s flags_out
);
  import branch_unit_pkg::*;

  // ----------------------------------------------------------------
  // Condition test
  // ----------------------------------------------------------------
  typedef enum logic {st_idle, st_refetch} state_e;

  state_e state;
  logic accept;
  logic cond_true;
  logic [PC_W-1:0] next_pc;

  // Issues during refetch are ignored; the core must stall them
  assign accept = branch_issue && (state == st_idle);

  // Pure read of the flags, nothing here writes them back
  always_comb begin
    cond_true = 1'b0;
    unique case (cmd.cond)
      branch_equal: cond_true = cmd.flags.result_null_flg; // RQ1
      branch_not_equal: cond_true = !cmd.flags.result_null_flg; // RQ1
      branch_carry_set: cond_true = cmd.flags.unsigned_overflow_bit; // RQ2
      branch_carry_clear: cond_true = !cmd.flags.unsigned_overflow_bit; // RQ2
      branch_same_or_higher: cond_true = !cmd.flags.unsigned_overflow_bit; // RQ3
      branch_lower_unsigned: cond_true = cmd.flags.unsigned_overflow_bit; // RQ3
      branch_minus: cond_true = cmd.flags.msb_result_bit; // RQ4
      branch_plus: cond_true = !cmd.flags.msb_result_bit; // RQ4
      branch_greater_equal_signed: begin
        cond_true = (cmd.flags.msb_result_bit ^ cmd.flags.twos_wrap_bit) == 1'b0; // RQ5
      end
      branch_less_signed: begin
        cond_true = (cmd.flags.msb_result_bit ^ cmd.flags.twos_wrap_bit) == 1'b1; // RQ6
      end
      branch_half_carry_set: cond_true = cmd.flags.nibble_carry; // RQ7
      branch_half_carry_clear: cond_true = !cmd.flags.nibble_carry; // RQ8
      branch_spare_flag_set: cond_true = cmd.flags.spare_flag; // RQ9
      default: cond_true = 1'b0; // Unused codes never branch
    endcase
  end

  // ----------------------------------------------------------------
  // Target arithmetic
  // ----------------------------------------------------------------
  // Offset is signed; sign extend so backward branches wrap correctly
  assign next_pc = cmd.pc + {{(PC_W-K_W){cmd.offset[K_W-1]}}, cmd.offset} + PC_STEP; // RQ10

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Taken branches spend one extra cycle while the new address is fetched
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= st_idle;
      busy <= 1'b0;
      pc_load <= 1'b0;
    end else if (accept && cond_true) begin
      state <= st_refetch; // RQ13
      busy <= 1'b1;
      pc_load <= 1'b1; // RQ10
    end else begin
      state <= st_idle; // RQ12
      busy <= 1'b0;
      pc_load <= 1'b0;
    end
  end

  // Completion strobe and outcome
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done <= 1'b0;
      taken <= 1'b0;
    end else if (state == st_refetch) begin
      done <= 1'b1; // RQ13
      taken <= 1'b1;
    end else if (accept && !cond_true) begin
      done <= 1'b1; // RQ13
      taken <= 1'b0;
    end else begin
      done <= 1'b0;
      taken <= 1'b0;
    end
  end

  // Target holds its last value; only pc_load says when it is meaningful
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pc_target <= PC_RESET;
    end else if (accept && cond_true) begin
      pc_target <= next_pc; // RQ10
    end
  end

  // Flags are passed through untouched so the status register keeps them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_out <= FLAGS_RESET;
    end else if (accept) begin
      flags_out <= cmd.flags; // RQ11
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_issue_taken;
    accept && cond_true;
  endsequence

  sequence s_refetch;
    busy && !done ##1 done && taken && !busy;
  endsequence

  sequence s_issue_plain;
    accept && !cond_true;
  endsequence

  a_equal_cond: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ1
    accept && (cmd.cond inside {branch_equal, branch_not_equal}) |=>
    pc_load == ($past(cmd.flags.result_null_flg) ^ ($past(cmd.cond) == branch_not_equal)))
    else $error("equal branch outcome wrong");

  a_carry_cond: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ2
    accept && (cmd.cond inside {branch_carry_set, branch_carry_clear}) |=>
    pc_load == ($past(cmd.flags.unsigned_overflow_bit) ^ ($past(cmd.cond) == branch_carry_clear)))
    else $error("carry branch outcome wrong");

  a_unsigned_cmp: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ3
    accept && (cmd.cond inside {branch_same_or_higher, branch_lower_unsigned}) |=>
    pc_load == ($past(cmd.flags.unsigned_overflow_bit) ^ ($past(cmd.cond) == branch_same_or_higher)))
    else $error("unsigned compare branch wrong");

  a_sign_cond: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ4
    accept && (cmd.cond inside {branch_minus, branch_plus}) |=>
    pc_load == ($past(cmd.flags.msb_result_bit) ^ ($past(cmd.cond) == branch_plus)))
    else $error("sign branch outcome wrong");

  a_signed_ge: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ5
    accept && cmd.cond == branch_greater_equal_signed |->
    ##1 pc_load == !($past(cmd.flags.msb_result_bit) ^ $past(cmd.flags.twos_wrap_bit)))
    else $error("signed ge branch wrong");

  a_signed_lt: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ6
    accept && cmd.cond == branch_less_signed |->
    ##1 pc_load == ($past(cmd.flags.msb_result_bit) ^ $past(cmd.flags.twos_wrap_bit)))
    else $error("signed lt branch wrong");

  a_half_set: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ7
    accept && cmd.cond == branch_half_carry_set |=>
    pc_load == $past(cmd.flags.nibble_carry) && done == !$past(cmd.flags.nibble_carry))
    else $error("half carry set taken wrongly");

  a_half_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ8
    accept && cmd.cond == branch_half_carry_clear |=> pc_load == !$past(cmd.flags.nibble_carry))
    else $error("half carry clear branch wrong");

  a_spare_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ9
    accept && cmd.cond == branch_spare_flag_set |=> pc_load == $past(cmd.flags.spare_flag))
    else $error("spare flag branch wrong");

  a_target_value: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ10
    s_issue_taken |=> pc_load && pc_target == PC_W'($past(cmd.pc) + PC_W'($signed($past(cmd.offset))) + 1))
    else $error("branch target wrong");

  a_flags_kept: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ11
    accept |=> flags_out == $past(cmd.flags) ##1 ($past(accept) || flags_out == $past(flags_out)))
    else $error("flags altered by branch");

  // Between issues the copy must not drift, or the status register would pick up garbage
  a_flags_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ11
    !accept |=> $stable(flags_out))
    else $error("flags copy changed without issue");

  a_target_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ10
    !(accept && cond_true) |=> $stable(pc_target))
    else $error("target changed without taken branch");

  a_cycle_bound: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ12
    accept |-> ##[1:2] done)
    else $error("branch did not finish in two cycles");

  a_taken_two: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
    s_issue_taken |=> s_refetch)
    else $error("taken branch not two cycles");

  a_skip_one: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
    s_issue_plain |=> done && !taken && !busy && !pc_load)
    else $error("untaken branch not one cycle");

  // A stray issue in the refetch cycle must not start a second load
  a_refetch_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
    state == st_refetch |=> !pc_load && !busy)
    else $error("issue accepted during refetch");

endmodule

// ==== branch_unit_pkg.sv ====
// Shared types and constants for the conditional branch unit.
// Assumes the fetch stage hands over an already decoded condition select.
package branch_unit_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int K_W = 7;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam int CYC_NOT_TAKEN = 1;
  localparam int CYC_TAKEN = 2;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Condition selects
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    branch_equal,
    branch_not_equal,
    branch_carry_set,
    branch_carry_clear,
    branch_same_or_higher,
    branch_lower_unsigned,
    branch_minus,
    branch_plus,
    branch_greater_equal_signed,
    branch_less_signed,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_spare_flag_set
  } cond_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spare_flag;
    logic nibble_carry;
    logic twos_wrap_bit;
    logic msb_result_bit;
    logic result_null_flg;
    logic unsigned_overflow_bit;
  } flags_s;

  localparam flags_s FLAGS_RESET = '0;

  typedef struct packed {
    cond_e cond;
    logic [K_W-1:0] offset;
    logic [PC_W-1:0] pc;
    flags_s flags;
  } branch_cmd_s;

endpackage

// ==== tb.sv ====
// Self-checking testbench for the conditional branch unit.
// Assumes the unit's own assertions are active; the bench drives issue and command directly.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import branch_unit_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic clk_sys;
  logic sys_rst;
  logic branch_issue;
  branch_cmd_s cmd;
  logic pc_load;
  logic [PC_W-1:0] pc_target;
  logic busy;
  logic done;
  logic taken;
  flags_s flags_out;
  int err_count;
  int checks;
  // Flag patterns that set every condition both ways, including both sign mismatch cases
  flags_s fl [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};

  conditional_branch_unit i_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .branch_issue(branch_issue),
    .cmd(cmd),
    .pc_load(pc_load),
    .pc_target(pc_target),
    .busy(busy),
    .done(done),
    .taken(taken),
    .flags_out(flags_out)
  );

  // Clock at 100 MHz
  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Independent condition table; unused codes never branch
  function automatic logic cond_hit(input cond_e c, input flags_s f);
    case (c)
      branch_equal: return f.result_null_flg;
      branch_not_equal: return !f.result_null_flg;
      branch_carry_set, branch_lower_unsigned: return f.unsigned_overflow_bit;
      branch_carry_clear, branch_same_or_higher: return !f.unsigned_overflow_bit;
      branch_minus: return f.msb_result_bit;
      branch_plus: return !f.msb_result_bit;
      branch_greater_equal_signed: return !(f.msb_result_bit ^ f.twos_wrap_bit);
      branch_less_signed: return f.msb_result_bit ^ f.twos_wrap_bit;
      branch_half_carry_set: return f.nibble_carry;
      branch_half_carry_clear: return !f.nibble_carry;
      branch_spare_flag_set: return f.spare_flag;
      default: return 1'b0;
    endcase
  endfunction

  // One branch; poke re-issues during the refetch cycle, which must be ignored
  task automatic run_branch(input cond_e c, input flags_s f, input logic [6:0] k, input logic [15:0] pc,
                            input logic poke);
    logic exp_t;
    logic [15:0] exp_pc;
    int lat;
    exp_t = cond_hit(c, f);
    exp_pc = pc + {{9{k[6]}}, k} + PC_STEP;
    @(posedge clk_sys);
    #1;
    branch_issue = 1'b1;
    cmd = '{cond: c, offset: k, pc: pc, flags: f};
    @(posedge clk_sys);
    #1;
    branch_issue = poke & exp_t;
    cmd.pc = ~pc;
    check("pc_load", pc_load, exp_t);
    check("busy", busy, exp_t);
    check("done_first", done, !exp_t);
    check("flags_out", flags_out, f);
    lat = done ? 1 : 0;
    if (exp_t) begin
      check("pc_target", pc_target, exp_pc);
      @(posedge clk_sys);
      #1;
      branch_issue = 1'b0;
      check("done_second", done, 1'b1);
      if (lat == 0 && done) lat = 2;
      check("taken", taken, 1'b1);
      check("pc_load_once", pc_load, 1'b0);
    end else begin
      check("not_taken", taken, 1'b0);
    end
    check("latency", 16'(lat), exp_t ? 16'(CYC_TAKEN) : 16'(CYC_NOT_TAKEN));
    // Nothing further may answer, including a dropped re-issue
    @(posedge clk_sys);
    #1;
    check("done_quiet", done, 1'b0);
    check("load_quiet", pc_load, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    branch_issue = 1'b0;
    cmd = '0;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check("rst_target", pc_target, PC_RESET);
    check("rst_flags", flags_out, FLAGS_RESET);
    check("rst_done", done, 1'b0);
    // Every code, four flag sets; offsets at both signed extremes, pc near wrap
    for (int c = 0; c < 16; c++) begin
      for (int i = 0; i < 4; i++) begin
        run_branch(cond_e'(c[3:0]), fl[i], c[0] ? 7'h40 : 7'h3f, i[0] ? 16'hfff0 : 16'h0010, i == 3);
      end
    end
    finish_test;
  end

  // Cuts a hang short; the full run needs well under this many cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    finish_test;
  end
endmodule
